/* bench/adcr_result_trigger_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

// ==================================================================
// port checker
module adcr_chk
  import adcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rd_data_o,
  input wire logic conv_done_i,
  input wire logic conv_start_o,
  input wire logic conv_enable_o,
  input wire logic comparator_mux_enable_o,
  input wire logic [NUM_PINS-1:0] port_input_o,
  input wire logic [NUM_PINS-1:0] buffer_enable_o
);
  // shadow of the two control bits the checks depend on
  logic ladj;
  logic ate;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ladj <= 1'b0;
      ate <= 1'b0;
    end else if (wr_en_i) begin
      if (addr_i == ADDR_MUX_SELECT) ladj <= wr_data_i[MS_LEFT_ADJUST_BIT];
      if (addr_i == ADDR_CONVERTER_CONTROL) ate <= wr_data_i[CC_AUTO_TRIGGER_BIT];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_rd_idle;
    !$past(rd_en_i) |-> rd_data_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_right;
    $past(rd_en_i && addr_i == ADDR_RESULT_HIGH && !ladj) |-> rd_data_o[7:2] == 6'h00;
  endproperty
  a_right: assert property (p_right) else $error("right layout high bits");
  property p_left;
    $past(rd_en_i && addr_i == ADDR_RESULT_LOW && ladj) |-> rd_data_o[5:0] == 6'h00;
  endproperty
  a_left: assert property (p_left) else $error("left layout low bits");
  property p_tc_rsv;
    $past(rd_en_i && addr_i == ADDR_TRIGGER_CONTROL) |-> !rd_data_o[7] && rd_data_o[5:3] == 3'h0;
  endproperty
  a_tc_rsv: assert property (p_tc_rsv) else $error("reserved trigger bits");
  property p_cme;
    $past(wr_en_i && addr_i == ADDR_TRIGGER_CONTROL) |->
      comparator_mux_enable_o == $past(wr_data_i[TC_COMPARATOR_MUX_BIT]);
  endproperty
  a_cme: assert property (p_cme) else $error("comparator mux bit");
  property p_ibd;
    $past(wr_en_i && addr_i == ADDR_INPUT_BUFFER_DISABLE, 2) && !$past(wr_en_i) |->
      buffer_enable_o == ~$past(wr_data_i, 2);
  endproperty
  a_ibd: assert property (p_ibd) else $error("buffer enable");
  property p_mask;
    (~buffer_enable_o & ~$past(buffer_enable_o) & port_input_o) == 8'h00;
  endproperty
  a_mask: assert property (p_mask) else $error("disabled pin reads one");
  property p_auto;
    conv_start_o && !$past(wr_en_i) && !$past(wr_en_i, 2) |-> $past(ate) || $past(ate, 2);
  endproperty
  a_auto: assert property (p_auto) else $error("start without auto trigger");
  property p_en;
    conv_start_o |-> conv_enable_o || $past(conv_enable_o);
  endproperty
  a_en: assert property (p_en) else $error("start while disabled");
  cover property (conv_start_o && conv_enable_o);
  cover property (rd_en_i && addr_i == ADDR_RESULT_LOW && ladj);
  cover property (port_input_o != 8'h00);
endmodule // adcr_chk

bind adcr_result_trigger adcr_chk u_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .conv_done_i(conv_done_i),
  .conv_start_o(conv_start_o), .conv_enable_o(conv_enable_o),
  .comparator_mux_enable_o(comparator_mux_enable_o), .port_input_o(port_input_o),
  .buffer_enable_o(buffer_enable_o)
);

`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

// ==================================================================
// bench top
module tb_top
  import adcr_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = 3'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic conv_done_i = 1'b0;
  logic [RESULT_W-1:0] conv_data_i = 10'h000;
  logic [NUM_TRIG_FLAGS-1:0] trig_flags_i = 7'h00;
  logic [NUM_PINS-1:0] pin_level_i = 8'h00;
  logic conv_busy_i = 1'b0;
  logic [7:0] rd_data_o, port_input_o, buffer_enable_o;
  logic conv_start_o, conv_enable_o, cme;
  logic [CC_PRESCALE_W-1:0] presc;
  logic [MS_CHANNEL_W-1:0] chan_sel;
  logic [MS_REFERENCE_W-1:0] ref_sel;
  int errors = 0, tests_run = 0, starts = 0, cyc = 0;
  int res = 0, lock = 0, ladj = 0, cc = 0;

  adcr_result_trigger uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .conv_busy_i(conv_busy_i),
    .conv_start_o(conv_start_o), .conv_enable_o(conv_enable_o),
    .prescale_select_o(presc), .channel_select_o(chan_sel), .reference_select_o(ref_sel),
    .comparator_mux_enable_o(cme), .trig_flags_i(trig_flags_i),
    .pin_level_i(pin_level_i), .port_input_o(port_input_o),
    .buffer_enable_o(buffer_enable_o)
  );

  always #4 clk_i = ~clk_i;

  // start pulses are counted at the edge that ends them; also the hang limit
  always @(posedge clk_i) begin
    cyc++;
    if (conv_start_o === 1'b1) starts++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // ==================================================================
  // tasks and model
  task automatic wrap_up();
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rb(input int hi);
    logic [15:0] v;
    v = ladj ? 16'(res << 6) : 16'(res);
    return hi ? v[15:8] : v[7:0];
  endfunction

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1 chk(rd_data_o, e);
    if (a == ADDR_RESULT_LOW) lock = 1;
    if (a == ADDR_RESULT_HIGH) lock = 0;
  endtask

  task automatic conv(input logic [9:0] d);
    @(posedge clk_i);
    conv_done_i <= 1'b1;
    conv_data_i <= d;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    if (!lock) res = d;
    cc |= 16;
  endtask

  task automatic stc(input int n);
    repeat (4) @(posedge clk_i);
    #1 chk(16'(starts), 16'(n));
    starts = 0;
    @(posedge clk_i);
  endtask

  // ==================================================================
  // tests
  initial begin
    void'($urandom(85));
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) rd(3'(a), 8'h00);
    chk(buffer_enable_o, 8'hff);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      conv(10'($urandom));
      ladj = k % 2;
      wr(ADDR_MUX_SELECT, 8'(ladj << 5));
      rd(ADDR_RESULT_LOW, rb(0));
      rd(ADDR_RESULT_HIGH, rb(1));
    end
    $display("test layout done");
    conv(10'h2a5);
    rd(ADDR_RESULT_LOW, rb(0));
    conv(10'($urandom));
    rd(ADDR_RESULT_HIGH, rb(1));
    conv(10'h0f3);
    rd(ADDR_RESULT_LOW, rb(0));
    rd(ADDR_RESULT_HIGH, rb(1));
    rd(ADDR_CONVERTER_CONTROL, 8'(cc));
    wr(ADDR_CONVERTER_CONTROL, 8'h10);
    cc = 0;
    rd(ADDR_CONVERTER_CONTROL, 8'h00);
    $display("test lock done");
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_CONVERTER_CONTROL, m ? 8'ha0 : 8'h80);
      for (int s = 1; s < 8; s++) begin
        wr(ADDR_TRIGGER_CONTROL, 8'(s));
        trig_flags_i <= 7'(1 << (s - 1));
        stc(m);
        trig_flags_i <= 7'h00;
      end
    end
    @(posedge clk_i);
    trig_flags_i <= 7'h01;
    wr(ADDR_TRIGGER_CONTROL, 8'h02);
    stc(0);
    wr(ADDR_TRIGGER_CONTROL, 8'h01);
    stc(1);
    trig_flags_i <= 7'h00;
    conv(10'($urandom));
    wr(ADDR_TRIGGER_CONTROL, 8'h00);
    stc(0);
    conv(10'($urandom));
    stc(1);
    wr(ADDR_CONVERTER_CONTROL, 8'h00);
    $display("test trigger done");
    wr(ADDR_TRIGGER_CONTROL, 8'h7f);
    rd(ADDR_TRIGGER_CONTROL, 8'h47);
    chk(16'(cme), 16'h1);
    wr(ADDR_TRIGGER_CONTROL, 8'h00);
    for (int k = 0; k < 3; k++) begin
      logic [7:0] d, p;
      d = 8'($urandom);
      p = 8'($urandom);
      @(posedge clk_i);
      pin_level_i <= p;
      wr(ADDR_INPUT_BUFFER_DISABLE, d);
      repeat (4) @(posedge clk_i);
      #1 chk(buffer_enable_o, 8'(~d));
      chk(port_input_o, 8'(p & ~d));
      rd(ADDR_INPUT_BUFFER_DISABLE, d);
    end
    $display("test buffers done");
    for (int k = 0; k < 2; k++) begin
      logic [7:0] v;
      v = 8'($urandom);
      wr(ADDR_MUX_SELECT, v);
      conv_busy_i <= v[6];
      wr(ADDR_CONVERTER_CONTROL, {v[7], 3'h0, v[3:0]});
      #1 chk(16'({ref_sel, chan_sel}), 16'({v[7:6], v[4:0]}));
      chk(16'({conv_enable_o, presc}), 16'({v[7], v[2:0]}));
      rd(ADDR_MUX_SELECT, v);
      rd(ADDR_CONVERTER_CONTROL, 8'(cc) | {v[7], v[6], 2'h0, v[3:0]});
    end
    // a start written together with the enable is a one-shot request
    wr(ADDR_CONVERTER_CONTROL, 8'hc0);
    stc(1);
    $display("test outputs done");
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire

/* logic/adcr_result_trigger.sv */
// Function
// - a finished conversion loads its 10-bit result into the result byte pair
// - reading the low byte freezes both result bytes until the high byte is read
// - right adjust: result 9:8 in high bits 1:0, 7:0 in low, rest zero
// - left adjust: result 9:2 in high byte, 1:0 in low bits 7:6, rest zero
// - trigger source select does nothing while auto trigger is disabled
// - auto trigger starts a conversion on each rising edge of the selected flag
// - switching from a clear source to a set one is an edge; starts if enabled
// - selecting free running, code 0, never makes a trigger event by itself
// - source codes: free, comparator, ext int 0, t0 cmp, t0 ovf, cmp B, t1 ovf, t1 cap
// - a one in an input buffer disable bit turns off that pin's input buffer
// - from one cycle after a pin's disable bit is set, its port input bit reads zero
// - a change of left adjust alters the presented layout at once
// - conversion end sets the done flag; writing one clears it
// - writing one to auto trigger enable allows starts on positive trigger edges
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module adcr_result_trigger
  import adcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  // converter core
  input wire logic conv_done_i,
  input wire logic [RESULT_W-1:0] conv_data_i,
  input wire logic conv_busy_i,
  output logic conv_start_o,
  output logic conv_enable_o,
  output logic [CC_PRESCALE_W-1:0] prescale_select_o,
  output logic [MS_CHANNEL_W-1:0] channel_select_o,
  output logic [MS_REFERENCE_W-1:0] reference_select_o,
  output logic comparator_mux_enable_o,
  // peripheral flags, indexed by trigger source code minus one
  input wire logic [NUM_TRIG_FLAGS-1:0] trig_flags_i,
  // analog pins
  input wire logic [NUM_PINS-1:0] pin_level_i,
  output logic [NUM_PINS-1:0] port_input_o,
  output logic [NUM_PINS-1:0] buffer_enable_o
);

  // ==================================================================
  // state
  typedef struct packed {
    // result pair and its read lock
    logic [RESULT_W-1:0] result;
    logic locked;
    // converter_control image
    logic done_flag;
    logic enable;
    logic auto_trigger;
    logic irq_enable;
    logic [CC_PRESCALE_W-1:0] prescale;
    // mux_select_register image
    logic [7:0] mux_select;
    // trigger_control image and the trigger edge detector
    logic comparator_mux;
    logic [TC_SOURCE_W-1:0] trig_sel;
    logic [TC_SOURCE_W-1:0] prev_sel;
    logic prev_level;
    // pin buffers
    logic [NUM_PINS-1:0] buffer_disable;
    logic [NUM_PINS-1:0] buffer_enable;
    // registered outputs
    logic [7:0] rd_data;
    logic start;
    logic [NUM_PINS-1:0] port_input;
  } adcr_state_t;

  // buffer enables leave reset high, so the state cannot simply clear to
  // zero; everything else does
  localparam adcr_state_t RESET_STATE = '{
    buffer_disable: RESET_INPUT_BUFFER_DISABLE,
    buffer_enable: ~RESET_INPUT_BUFFER_DISABLE,
    default: '0
  };

  adcr_state_t s;
  adcr_state_t next_s;

  logic [NUM_PINS-1:0] pin_sync;

  // ==================================================================
  // helpers

  // byte view of the stored result; the alignment is applied on read, so
  // a change of left adjust shows up without waiting for a conversion
  function automatic logic [7:0] present_byte(input logic [RESULT_W-1:0] res,
                                              input logic left_adj,
                                              input logic high);
    logic [7:0] b;
    b = 8'h00;
    if (left_adj) begin
      if (high) begin
        b = res[9:2];
      end else begin
        b = {res[1:0], 6'h00};
      end
    end else begin
      if (high) begin
        b = {6'h00, res[9:8]};
      end else begin
        b = res[7:0];
      end
    end
    return b;
  endfunction

  // one address decode shared by both lock strobes
  function automatic logic read_hit(input logic strobe,
                                    input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] target);
    return strobe && (addr == target);
  endfunction

  // level of the selected trigger source; free running follows the done flag
  function automatic logic source_level(input logic [TC_SOURCE_W-1:0] sel,
                                        input logic done,
                                        input logic [NUM_TRIG_FLAGS-1:0] flags);
    logic lvl;
    lvl = 1'b0;
    if (sel == ADCR_SRC_FREE_RUNNING) begin
      lvl = done;
    end else begin
      lvl = flags[sel - 3'h1];
    end
    return lvl;
  endfunction

  // ==================================================================
  // pin synchroniser
  adcr_sync2 #(
    .WIDTH(NUM_PINS)
  ) u_pin_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(pin_level_i),
    .sync_o(pin_sync)
  );

  // ==================================================================
  // next state
  always_comb begin
    logic level;
    logic edge_seen;
    logic free_run;
    logic auto_start;
    logic soft_start;
    logic low_read;
    logic high_read;
    logic left_adj;
    auto_start = 1'b0;
    level = source_level(s.trig_sel, s.done_flag, trig_flags_i);
    free_run = (s.trig_sel == ADCR_SRC_FREE_RUNNING);
    edge_seen = level & ~s.prev_level;
    low_read = read_hit(rd_en_i, addr_i, ADDR_RESULT_LOW);
    high_read = read_hit(rd_en_i, addr_i, ADDR_RESULT_HIGH);
    left_adj = s.mux_select[MS_LEFT_ADJUST_BIT];
    soft_start = 1'b0;

    next_s = s;
    next_s.start = 1'b0;
    next_s.rd_data = RESET_BYTE;
    next_s.prev_level = level;
    next_s.prev_sel = s.trig_sel;

    // free running restarts on each completion; a selection change into it
    // is never an edge, so the done flag already being set does not matter
    if (free_run) begin
      auto_start = s.auto_trigger & s.enable & conv_done_i;
    end else begin
      auto_start = s.auto_trigger & s.enable & edge_seen;
    end

    // ---------------- register reads ----------------
    if (rd_en_i) begin
      unique case (addr_i)
        ADDR_RESULT_LOW: begin
          next_s.rd_data = present_byte(s.result, left_adj, 1'b0);
        end
        ADDR_RESULT_HIGH: begin
          next_s.rd_data = present_byte(s.result, left_adj, 1'b1);
        end
        ADDR_TRIGGER_CONTROL: begin
          next_s.rd_data = {1'b0, s.comparator_mux, 3'h0, s.trig_sel};
        end
        ADDR_INPUT_BUFFER_DISABLE: begin
          next_s.rd_data = s.buffer_disable;
        end
        ADDR_CONVERTER_CONTROL: begin
          next_s.rd_data = {s.enable, conv_busy_i | s.start, s.auto_trigger,
                            s.done_flag, s.irq_enable, s.prescale};
        end
        ADDR_MUX_SELECT: begin
          next_s.rd_data = s.mux_select;
        end
        default: begin
          next_s.rd_data = RESET_BYTE;
        end
      endcase
    end

    // freeze on low-byte read, release on high-byte read
    if (low_read) begin
      next_s.locked = 1'b1;
    end
    if (high_read) begin
      next_s.locked = 1'b0;
    end

    // ---------------- register writes ----------------
    if (wr_en_i) begin
      unique case (addr_i)
        ADDR_TRIGGER_CONTROL: begin
          // bit 7 and bits 5:3 are not stored
          next_s.comparator_mux = wr_data_i[TC_COMPARATOR_MUX_BIT];
          next_s.trig_sel = wr_data_i[TC_SOURCE_LSB +: TC_SOURCE_W];
        end
        ADDR_INPUT_BUFFER_DISABLE: begin
          next_s.buffer_disable = wr_data_i;
        end
        ADDR_CONVERTER_CONTROL: begin
          next_s.enable = wr_data_i[CC_ENABLE_BIT];
          next_s.auto_trigger = wr_data_i[CC_AUTO_TRIGGER_BIT];
          next_s.irq_enable = wr_data_i[CC_IRQ_ENABLE_BIT];
          next_s.prescale = wr_data_i[CC_PRESCALE_LSB +: CC_PRESCALE_W];
          if (wr_data_i[CC_DONE_FLAG_BIT]) begin
            next_s.done_flag = 1'b0;
          end
          // writing zero to start has no effect; a start needs the enable
          soft_start = wr_data_i[CC_START_BIT] & wr_data_i[CC_ENABLE_BIT];
        end
        ADDR_MUX_SELECT: begin
          next_s.mux_select = wr_data_i;
        end
        default: begin
          next_s.mux_select = s.mux_select;
        end
      endcase
    end

    // ---------------- conversion completion ----------------
    // placed after the write so that a completion beats a same-cycle clear
    if (conv_done_i) begin
      next_s.done_flag = 1'b1;
      // a low-byte read in this very cycle already counts as locking
      if (!(s.locked || low_read)) begin
        next_s.result = conv_data_i;
      end
    end

    // start is a single-cycle pulse; the core ignores it while busy
    next_s.start = soft_start | auto_start;

    // ---------------- pins ----------------
    next_s.port_input = pin_sync & ~s.buffer_disable;
    // the enable is kept as its own flop so the pin output needs no inverter
    next_s.buffer_enable = ~next_s.buffer_disable;
  end

  // ==================================================================
  // registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // ==================================================================
  // outputs, all straight from state flops
  assign rd_data_o = s.rd_data;
  assign conv_start_o = s.start;
  assign conv_enable_o = s.enable;
  assign prescale_select_o = s.prescale;
  assign channel_select_o = s.mux_select[MS_CHANNEL_LSB +: MS_CHANNEL_W];
  assign reference_select_o = s.mux_select[MS_REFERENCE_LSB +: MS_REFERENCE_W];
  assign comparator_mux_enable_o = s.comparator_mux;
  assign port_input_o = s.port_input;
  assign buffer_enable_o = s.buffer_enable;

endmodule // adcr_result_trigger

`default_nettype wire

/* logic/adcr_sync2.sv */
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for asynchronous pin levels
module adcr_sync2 #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } adcr_sync_state_t;

  adcr_sync_state_t s;
  adcr_sync_state_t next_s;

  // first stage feeds only the second stage
  always_comb begin
    next_s = s;
    next_s.meta = async_i;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.stable;

endmodule // adcr_sync2

`default_nettype wire

/* pkg/adcr_pkg.sv */
package adcr_pkg;

  // ==================================================================
  // register map (8-bit registers on a plain strobe port)
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] ADDR_RESULT_LOW = 3'h0;
  localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
  localparam logic [2:0] ADDR_TRIGGER_CONTROL = 3'h2;
  localparam logic [2:0] ADDR_INPUT_BUFFER_DISABLE = 3'h3;
  localparam logic [2:0] ADDR_CONVERTER_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_MUX_SELECT = 3'h5;

  // ==================================================================
  // converter_control fields
  localparam int unsigned CC_ENABLE_BIT = 7;
  localparam int unsigned CC_START_BIT = 6;
  localparam int unsigned CC_AUTO_TRIGGER_BIT = 5;
  localparam int unsigned CC_DONE_FLAG_BIT = 4;
  localparam int unsigned CC_IRQ_ENABLE_BIT = 3;
  localparam int unsigned CC_PRESCALE_LSB = 0;
  localparam int unsigned CC_PRESCALE_W = 3;

  // ==================================================================
  // mux_select_register fields
  localparam int unsigned MS_REFERENCE_LSB = 6;
  localparam int unsigned MS_REFERENCE_W = 2;
  localparam int unsigned MS_LEFT_ADJUST_BIT = 5;
  localparam int unsigned MS_CHANNEL_LSB = 0;
  localparam int unsigned MS_CHANNEL_W = 5;

  // ==================================================================
  // trigger_control fields
  localparam int unsigned TC_COMPARATOR_MUX_BIT = 6;
  localparam int unsigned TC_SOURCE_LSB = 0;
  localparam int unsigned TC_SOURCE_W = 3;

  // ==================================================================
  // trigger source codes
  typedef enum logic [2:0] {
    ADCR_SRC_FREE_RUNNING = 3'h0,
    ADCR_SRC_COMPARATOR = 3'h1,
    ADCR_SRC_EXT_INT0 = 3'h2,
    ADCR_SRC_TIMER0_COMPARE = 3'h3,
    ADCR_SRC_TIMER0_OVERFLOW = 3'h4,
    ADCR_SRC_TIMER_COMPARE_B = 3'h5,
    ADCR_SRC_TIMER1_OVERFLOW = 3'h6,
    ADCR_SRC_TIMER1_CAPTURE = 3'h7
  } adcr_source_t;

  // ==================================================================
  // widths and reset values
  localparam int unsigned RESULT_W = 10;
  localparam int unsigned NUM_TRIG_FLAGS = 7;
  localparam int unsigned NUM_PINS = 8;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [9:0] RESET_RESULT = 10'h000;
  localparam logic [7:0] RESET_INPUT_BUFFER_DISABLE = 8'h00;

endpackage
